// file: logic/pat_trace.sv
// Program address trace driver for the external memory address bus
// What this block does
// - Trace enable drives internal fetch addresses out
// - External accesses take the bus first
// - No strobes or chip select on trace
// - Strobe pulses on every new address
// - Newest held fetch traced, taken or not; a later fetch overwrites one still waiting
// - Address changes mid output clock low
`timescale 1ns/1ps
`default_nettype none
`include "pat_defs.svh"

module pat_trace
    import pat_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        address_trace_enable_bit_i,
    input  wire logic        fetch_valid_i,
    input  wire logic [15:0] fetch_addr_i,
    input  wire logic        ext_valid_i,
    input  wire logic [15:0] ext_addr_i,
    input  wire logic        ext_read_i,
    output logic             output_clock_o,
    output logic [15:0]      addr_o,
    output logic             memory_chip_select_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             trace_address_strobe_n_o
);

    // ==========================================================
    // State
    // ==========================================================
    pat_state_type st;
    pat_state_type next_st;

    // ==========================================================
    // Next state
    // ==========================================================
    // Each core clock is a quarter of the output clock period
    always_comb begin
        next_st = st;
        // Capture requests; held until the bus slot comes round
        if (ext_valid_i) begin
            next_st.ext_hold.valid = 1'b1;
            next_st.ext_hold.addr  = ext_addr_i;
            next_st.ext_rd         = ext_read_i;
        end
        if (fetch_valid_i && address_trace_enable_bit_i) begin
            next_st.int_hold.valid = 1'b1;
            next_st.int_hold.addr  = fetch_addr_i;
        end
        case (st.phase)
            PAT_HIGH1: begin
                next_st.phase = PAT_HIGH2;
            end
            PAT_HIGH2: begin
                next_st.phase    = PAT_LOW1;
                next_st.oclk     = 1'b0;
                next_st.strobe_n = 1'b1;
                next_st.rd_n     = 1'b1;
                next_st.wr_n     = 1'b1;
            end
            PAT_LOW1: begin
                // bus moves at middle of low phase
                next_st.phase = PAT_LOW2;
                if (st.ext_hold.valid) begin
                    next_st.addr           = st.ext_hold.addr;
                    next_st.mcs_n          = 1'b0;
                    next_st.strobe_n       = 1'b0;
                    next_st.ext_hold.valid = ext_valid_i;
                    // Direction frozen now; a request arriving this cycle may overwrite ext_rd
                    next_st.cur_rd         = st.ext_rd;
                end else if (st.int_hold.valid && address_trace_enable_bit_i) begin
                    next_st.addr           = st.int_hold.addr;
                    next_st.mcs_n          = 1'b1;
                    next_st.strobe_n       = 1'b0;
                    next_st.int_hold.valid = fetch_valid_i;
                end else begin
                    next_st.mcs_n = 1'b1;
                end
            end
            PAT_LOW2: begin
                next_st.phase = PAT_HIGH1;
                next_st.oclk  = 1'b1;
                // Strobes only for genuine external accesses
                if (!st.mcs_n) begin
                    next_st.rd_n = ~st.cur_rd;
                    next_st.wr_n = st.cur_rd;
                end
            end
            default: begin
                next_st.phase = PAT_HIGH1;
            end
        endcase
        if (!address_trace_enable_bit_i) begin
            next_st.int_hold.valid = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st.phase    <= PAT_HIGH1;
            st.oclk     <= 1'b1;
            st.addr     <= `PAT_ADDR_RST;
            st.mcs_n    <= 1'b1;
            st.rd_n     <= 1'b1;
            st.wr_n     <= 1'b1;
            st.strobe_n <= 1'b1;
            st.ext_hold <= '0;
            st.int_hold <= '0;
            st.ext_rd   <= 1'b0;
            st.cur_rd   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign output_clock_o           = st.oclk;
    assign addr_o                   = st.addr;
    assign memory_chip_select_n_o   = st.mcs_n;
    assign rd_n_o                   = st.rd_n;
    assign wr_n_o                   = st.wr_n;
    assign trace_address_strobe_n_o = st.strobe_n;

    // ==========================================================
    // Checks
    // ==========================================================
    // Strobe stays low for the rest of the output clock period
    sequence s_strobe_tail;
        !st.strobe_n ##1 !st.strobe_n ##1 st.strobe_n;
    endsequence

    // Exactly one command strobe low through the high phase, then released
    sequence s_cmd_window;
        (st.rd_n ^ st.wr_n) ##1 (st.rd_n ^ st.wr_n) ##1 (st.rd_n && st.wr_n);
    endsequence

    property p_trace_no_select;
        @(posedge clk_i) disable iff (!nrst_i)
        ($fell(st.strobe_n) && st.mcs_n) |-> ##1 (st.rd_n && st.wr_n)[*4];
    endproperty
    a_trace_no_select: assert property (p_trace_no_select)
        else $error("strobe on trace");

    property p_strobe_on_new;
        @(posedge clk_i) disable iff (!nrst_i)
        (st.phase == PAT_LOW1 && st.ext_hold.valid) |=> !st.strobe_n && !st.mcs_n;
    endproperty
    a_strobe_on_new: assert property (p_strobe_on_new)
        else $error("no strobe for access");

    property p_ext_first;
        @(posedge clk_i) disable iff (!nrst_i)
        (st.phase == PAT_LOW1 && st.ext_hold.valid) |=> st.addr == $past(st.ext_hold.addr);
    endproperty
    a_ext_first: assert property (p_ext_first)
        else $error("external lost priority");

    property p_trace_drive;
        @(posedge clk_i) disable iff (!nrst_i)
        (st.phase == PAT_LOW1 && !st.ext_hold.valid && st.int_hold.valid
         && address_trace_enable_bit_i) |=> st.addr == $past(st.int_hold.addr) && st.mcs_n;
    endproperty
    a_trace_drive: assert property (p_trace_drive)
        else $error("trace address missing");

    property p_mid_low;
        @(posedge clk_i) disable iff (!nrst_i)
        $changed(st.addr) |-> st.phase == PAT_LOW2 && !st.oclk;
    endproperty
    a_mid_low: assert property (p_mid_low)
        else $error("address moved off mid low");

    property p_off_quiet;
        @(posedge clk_i) disable iff (!nrst_i)
        !address_trace_enable_bit_i |=> !st.int_hold.valid;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("trace pending while off");

    property p_fetch_kept;
        @(posedge clk_i) disable iff (!nrst_i)
        (fetch_valid_i && address_trace_enable_bit_i) |=> st.int_hold.valid;
    endproperty
    a_fetch_kept: assert property (p_fetch_kept)
        else $error("fetch dropped");

    property p_strobe_pulse;
        @(posedge clk_i) disable iff (!nrst_i)
        $fell(st.strobe_n) |=> s_strobe_tail;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("bad strobe width");

    property p_cmd_on_access;
        @(posedge clk_i) disable iff (!nrst_i)
        (st.phase == PAT_LOW2 && !st.mcs_n) |=> s_cmd_window;
    endproperty
    a_cmd_on_access: assert property (p_cmd_on_access)
        else $error("external access lacks one command strobe");

    property p_oclk_phase;
        @(posedge clk_i) disable iff (!nrst_i)
        st.oclk == (st.phase == PAT_HIGH1 || st.phase == PAT_HIGH2);
    endproperty
    a_oclk_phase: assert property (p_oclk_phase)
        else $error("output clock out of step with phase");

    property p_mcs_mid_low;
        @(posedge clk_i) disable iff (!nrst_i)
        $changed(st.mcs_n) |-> st.phase == PAT_LOW2;
    endproperty
    a_mcs_mid_low: assert property (p_mcs_mid_low)
        else $error("chip select moved off mid low");

    property p_off_no_strobe;
        @(posedge clk_i) disable iff (!nrst_i)
        (st.phase == PAT_LOW1 && !st.ext_hold.valid && !address_trace_enable_bit_i)
        |=> st.strobe_n;
    endproperty
    a_off_no_strobe: assert property (p_off_no_strobe)
        else $error("strobe while trace off");

endmodule : pat_trace
`default_nettype wire

// file: logic/pat_defs.svh
// Timing and reset constants for the program address trace block
`ifndef PAT_DEFS_SVH
`define PAT_DEFS_SVH

// Output clock divider: half period in core clocks
`define PAT_OCLK_HALF        4'h2
// Reset value of the address bus
`define PAT_ADDR_RST         16'h0000

`endif

// file: logic/pat_pkg.sv
// Types shared by the program address trace block
package pat_pkg;

    // Core-side request carrying one address
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } pat_req_type;

    // Pin-side phase of the output clock
    typedef enum logic [1:0] {
        PAT_HIGH1,
        PAT_HIGH2,
        PAT_LOW1,
        PAT_LOW2
    } pat_phase_type;

    // Whole state of the block
    typedef struct packed {
        pat_phase_type phase;
        logic          oclk;
        logic [15:0]   addr;
        logic          mcs_n;
        logic          rd_n;
        logic          wr_n;
        logic          strobe_n;
        pat_req_type   ext_hold;
        pat_req_type   int_hold;
        logic          ext_rd;
        logic          cur_rd;
    } pat_state_type;

endpackage : pat_pkg

// file: tb/pat_capture.sv
// Capture model that samples the traced address bus
`timescale 1ns/1ps
`default_nettype none
module pat_capture (
    input  wire logic        strobe_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        mcs_n_i,
    output var logic [15:0]  cap_addr_o,
    output var logic         cap_mcs_n_o,
    output var int           cap_count_o
);
    // ==========================================
    // Sampling
    initial begin
        cap_count_o = 0;
    end
    // sample at strobe fall
    // Short settle so bus and strobe launched together both land first
    always @(negedge strobe_n_i) begin
        #1;
        cap_addr_o = addr_i;
        cap_mcs_n_o = mcs_n_i;
        cap_count_o = cap_count_o + 1;
    end
endmodule // pat_capture
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the program address trace block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk       = 1'b0;
    logic        nrst_i    = 1'b0;
    logic        en        = 1'b0;
    logic        f_v       = 1'b0;
    logic        e_v       = 1'b0;
    logic        e_rd      = 1'b0;
    logic [15:0] f_a       = 16'h0000;
    logic [15:0] e_a       = 16'h0000;
    logic        oclk;
    logic        mcs_n;
    logic        rd_n;
    logic        wr_n;
    logic        stb_n;
    logic [15:0] addr;
    logic [15:0] c_addr;
    logic        c_mcs;
    logic        prev_ok   = 1'b0;
    logic        prev_oclk = 1'b1;
    logic        prev_mcs  = 1'b1;
    logic        rd_seen   = 1'b0;
    logic        wr_seen   = 1'b0;
    logic [15:0] prev;
    int          c_cnt;
    int          mismatches  = 0;
    int          checks_done = 0;
    int          n0;
    pat_trace uut (.clk_i(clk), .nrst_i(nrst_i), .address_trace_enable_bit_i(en),
        .fetch_valid_i(f_v), .fetch_addr_i(f_a), .ext_valid_i(e_v), .ext_addr_i(e_a),
        .ext_read_i(e_rd), .output_clock_o(oclk), .addr_o(addr),
        .memory_chip_select_n_o(mcs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .trace_address_strobe_n_o(stb_n));
    pat_capture cap (.strobe_n_i(stb_n), .addr_i(addr), .mcs_n_i(mcs_n),
        .cap_addr_o(c_addr), .cap_mcs_n_o(c_mcs), .cap_count_o(c_cnt));
    // ==========================================
    // Clock, watchdog and monitors
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        close_out();
    end
    // Memory strobes seen, sampled away from the edge that launches them
    always @(negedge clk) begin
        if (nrst_i && !rd_n) begin
            rd_seen = 1'b1;
        end
        if (nrst_i && !wr_n) begin
            wr_seen = 1'b1;
        end
    end
    // address and chip select move only mid low phase; reset jumps excluded
    always @(posedge clk) begin
        #1;
        if (prev_ok && nrst_i && (addr !== prev || mcs_n !== prev_mcs)) begin
            check1("oclk_at_bus_change", 1'b0, oclk);
            check1("oclk_before_bus_change", 1'b0, prev_oclk);
        end
        prev      = addr;
        prev_mcs  = mcs_n;
        prev_oclk = oclk;
        prev_ok   = nrst_i;
    end
    // ==========================================
    // Shared tasks
    task automatic check1(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic check16(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Waits for the next capture, bounded to three output clock periods
    task automatic expect_cap(input logic [15:0] a, input logic m);
        n0 = c_cnt;
        for (int i = 0; i < 12 && c_cnt == n0; i++) @(posedge clk);
        #2;
        check1("capture_seen", 1'b1, c_cnt != n0);
        check16("captured_addr", a, c_addr);
        check1("captured_mcs_n", m, c_mcs);
    endtask
    // One-cycle request pulse, changed only at falling edges
    task automatic req(input logic f, input logic [15:0] fa, input logic e,
                       input logic [15:0] ea, input logic rd);
        @(negedge clk);
        f_v  = f;
        f_a  = fa;
        e_v  = e;
        e_a  = ea;
        e_rd = rd;
        @(negedge clk);
        f_v = 1'b0;
        e_v = 1'b0;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_trace();
        logic [15:0] tv [3];
        tv = '{16'h1234, 16'h0100, 16'h0101};
        @(negedge clk);
        en      = 1'b1;
        rd_seen = 1'b0;
        wr_seen = 1'b0;
        foreach (tv[i]) begin
            req(1'b1, tv[i], 1'b0, 16'h0000, 1'b1);
            expect_cap(tv[i], 1'b1);
        end
        check1("read_during_trace", 1'b0, rd_seen);
        check1("write_during_trace", 1'b0, wr_seen);
        $display("test trace done");
    endtask
    task automatic t_ext();
        rd_seen = 1'b0;
        wr_seen = 1'b0;
        req(1'b1, 16'h0042, 1'b1, 16'hbeef, 1'b1);
        expect_cap(16'hbeef, 1'b0);
        expect_cap(16'h0042, 1'b1);
        check1("read_strobe_on_ext", 1'b1, rd_seen);
        check1("write_strobe_on_read", 1'b0, wr_seen);
        $display("test external priority done");
    endtask
    task automatic t_write();
        rd_seen = 1'b0;
        wr_seen = 1'b0;
        req(1'b0, 16'h0000, 1'b1, 16'h7a10, 1'b0);
        expect_cap(16'h7a10, 1'b0);
        // Write strobe sits in the high phase after the capture
        repeat (2) @(negedge clk);
        check1("write_strobe_on_ext", 1'b1, wr_seen);
        check1("read_strobe_on_write", 1'b0, rd_seen);
        $display("test external write done");
    endtask
    task automatic t_off();
        @(negedge clk);
        en = 1'b0;
        n0 = c_cnt;
        req(1'b1, 16'h5555, 1'b0, 16'h0000, 1'b1);
        repeat (12) @(posedge clk);
        #2;
        check1("no_trace_when_off", 1'b1, c_cnt == n0);
        check16("addr_held_when_off", 16'h7a10, addr);
        check1("mcs_n_idle_when_off", 1'b1, mcs_n);
        req(1'b1, 16'h5a5a, 1'b1, 16'h0c30, 1'b1);
        expect_cap(16'h0c30, 1'b0);
        repeat (8) @(posedge clk);
        #2;
        check16("no_fetch_after_ext_off", 16'h0c30, addr);
        check1("one_capture_when_off", 1'b1, c_cnt == n0 + 1);
        $display("test disabled done");
    endtask
    task automatic t_reset();
        @(negedge clk);
        nrst_i = 1'b0;
        #1;
        check16("addr_in_reset", 16'h0000, addr);
        check1("mcs_n_in_reset", 1'b1, mcs_n);
        check1("strobe_n_in_reset", 1'b1, stb_n);
        check1("oclk_in_reset", 1'b1, oclk);
        repeat (2) @(negedge clk);
        nrst_i = 1'b1;
        en     = 1'b1;
        req(1'b1, 16'h0a0b, 1'b0, 16'h0000, 1'b1);
        expect_cap(16'h0a0b, 1'b1);
        $display("test reset done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        nrst_i = 1'b1;
        t_trace();
        t_ext();
        t_write();
        t_off();
        t_reset();
        close_out();
    end
endmodule // testbench
`default_nettype wire
